// ===== tdc_pin_model.sv
// Model of the external count, trigger and gate sources wired to the counter pins.
`default_nettype none
module tdc_pin_model (
  input  wire logic       clk,
  output logic      [7:0] port_b_in,
  output logic      [3:0] port_c_in,
  output logic            hs_trigger
);
  timeunit 1ns;
  timeprecision 1ns;
  // Index 0..7 is port B, 8..11 port C, 12 the handshake trigger; all gates start high.
  logic [12:0] line_r = 13'h0888;
  assign {hs_trigger, port_c_in, port_b_in} = line_r;
  // Each level is held at least four clocks so the two-stage synchroniser never misses an edge.
  task automatic level(input int idx, input logic v);
    @(posedge clk);
    line_r[idx] <= v;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input int idx);
    level(idx, 1'b1);
    level(idx, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== tdc_pkg.sv
// Package with register map, field positions and reset values of the counter block.
`default_nettype none
package tdc_pkg;
  localparam int NCTR = 3;
  localparam int CW   = 16;
  // Per-counter register block: base is counter index times the stride; OFF_CFG and OFF_STAT are global addresses.
  localparam logic [7:0] CTR_STRIDE = 8'h20;
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_TC_LO  = 8'h08;
  localparam logic [7:0] OFF_TC_HI  = 8'h0c;
  localparam logic [7:0] OFF_CC_LO  = 8'h10;
  localparam logic [7:0] OFF_CC_HI  = 8'h14;
  localparam logic [7:0] OFF_CFG    = 8'h60;
  localparam logic [7:0] OFF_STAT   = 8'h64;
  // Mode register fields.
  localparam int MODE_EN    = 0;
  localparam int MODE_SGATE = 1;
  localparam int MODE_ECNT  = 2;
  localparam int MODE_ETRIG = 3;
  localparam int MODE_EGATE = 4;
  localparam int MODE_RETRG = 5;
  localparam int MODE_CONT  = 6;
  localparam int MODE_OM    = 7;
  localparam int MODE_IE    = 9;
  // Command bits on write, status bits on read.
  localparam int CMD_TRIG   = 0;
  localparam int CMD_FREEZE = 1;
  localparam int CMD_CLR_IP = 2;
  localparam int CMD_SET_US = 3;
  localparam int CMD_CLR_US = 4;
  // Global configuration fields.
  localparam int CFG_MIE    = 0;
  localparam int CFG_LTRIG  = 1;
  localparam int CFG_LGATE  = 2;
  localparam int CFG_LCNT   = 3;
  localparam logic [9:0]  MODE_RST = 10'h000;
  localparam logic [3:0]  CFG_RST  = 4'h0;
  localparam logic [15:0] TC_RST   = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  typedef enum logic [1:0] {
    TDC_PULSE   = 2'b00,
    TDC_ONESHOT = 2'b01,
    TDC_SQUARE  = 2'b10,
    TDC_SQ_ALT  = 2'b11
  } tdc_outmode_t;
endpackage
`default_nettype wire

// ===== tdc_timer.sv
// Three 16-bit down-counting counter/timers behind an Avalon-MM slave.
//
// Our own choices: the register offsets and the Avalon-MM register port.
`default_nettype none
module tdc_timer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [7:0]  port_b_in,
  input  wire logic [3:0]  port_c_in,
  input  wire logic        hs_trigger,
  input  wire logic        chain_enable_in,
  output logic      [7:0]  port_b_out,
  output logic      [7:0]  port_b_oe,
  output logic      [3:0]  port_c_out,
  output logic      [3:0]  port_c_oe,
  output logic             irq
);
  logic [9:0]  mode_r   [3];
  logic [15:0] tc_r     [3];
  logic [15:0] cnt_r    [3];
  logic [15:0] hold_r   [3];
  logic [3:0]  cfg_r;
  logic [2:0]  cip_r, out_r, ip_r, err_r, ovr_r, frz_r, ius_r;
  logic [2:0]  trig_prev_r, out_prev_r;
  logic [2:0]  cnt_s1_r, cnt_s2_r, cnt_s3_r;
  logic [2:0]  trg_s1_r, trg_s2_r, gat_s1_r, gat_s2_r;
  logic        div_r;
  logic [2:0]  en, sel_cmd, trig_src, trig_acc, tick, gate_ok, step, term, clr_ip;
  logic [2:0]  raw_cnt, raw_trg, raw_gat;
  logic [31:0] rd_nxt;
  logic        wr_go, rd_go;

  function automatic logic hit(input logic [7:0] a, input int n, input logic [7:0] off);
    logic [7:0] base;
    base = 8'(n) * tdc_pkg::CTR_STRIDE;
    return a == base + off;
  endfunction

  function automatic tdc_pkg::tdc_outmode_t om(input logic [9:0] m);
    return tdc_pkg::tdc_outmode_t'(m[tdc_pkg::MODE_OM +: 2]);
  endfunction

  // A request is taken at the edge where waitrequest is seen low.
  assign wr_go = write && !waitrequest;
  assign rd_go = read && !waitrequest;

  assign raw_cnt = {port_c_in[1], port_b_in[1], port_b_in[5]};
  assign raw_trg = {port_c_in[2], port_b_in[2], port_b_in[6]};
  assign raw_gat = {port_c_in[3], port_b_in[3], port_b_in[7]};

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      en[i] = mode_r[i][tdc_pkg::MODE_EN];
      sel_cmd[i] = wr_go && byteenable[0] && hit(address, i, tdc_pkg::OFF_CMD);
      clr_ip[i] = sel_cmd[i] && writedata[tdc_pkg::CMD_CLR_IP];
      trig_src[i] = (sel_cmd[i] && writedata[tdc_pkg::CMD_TRIG])
        || (mode_r[i][tdc_pkg::MODE_ETRIG] && trg_s2_r[i]);
      gate_ok[i] = mode_r[i][tdc_pkg::MODE_SGATE]
        && (!mode_r[i][tdc_pkg::MODE_EGATE] || gat_s2_r[i]);
      if (mode_r[i][tdc_pkg::MODE_ECNT]) begin
        tick[i] = cnt_s2_r[i] && !cnt_s3_r[i];
      end else begin
        tick[i] = div_r;
      end
    end
    trig_src[1] = trig_src[1] || (cfg_r[tdc_pkg::CFG_LTRIG] && !out_r[0]);
    trig_src[2] = trig_src[2] || hs_trigger;
    gate_ok[1] = gate_ok[1] && !(cfg_r[tdc_pkg::CFG_LGATE] && out_r[0]);
    // Linked counting applies only while counter 2 has external counting off.
    if (cfg_r[tdc_pkg::CFG_LCNT] && !mode_r[1][tdc_pkg::MODE_ECNT]) begin
      tick[1] = out_prev_r[0] && !out_r[0];
    end
    for (int i = 0; i < 3; i++) begin
      trig_acc[i] = trig_src[i] && !trig_prev_r[i] && en[i]
        && (!cip_r[i] || mode_r[i][tdc_pkg::MODE_RETRG]);
      step[i] = cip_r[i] && gate_ok[i] && tick[i] && !trig_acc[i];
      term[i] = step[i] && cnt_r[i] == tdc_pkg::CNT_ONE;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    for (int i = 0; i < 3; i++) begin
      if (hit(address, i, tdc_pkg::OFF_MODE)) rd_nxt = {22'h0, mode_r[i]};
      if (hit(address, i, tdc_pkg::OFF_CMD)) begin
        rd_nxt = {27'h0, ius_r[i], err_r[i], ip_r[i], frz_r[i], cip_r[i]};
      end
      if (hit(address, i, tdc_pkg::OFF_TC_LO)) rd_nxt = {24'h0, tc_r[i][7:0]};
      if (hit(address, i, tdc_pkg::OFF_TC_HI)) rd_nxt = {24'h0, tc_r[i][15:8]};
      if (hit(address, i, tdc_pkg::OFF_CC_LO)) begin
        rd_nxt = {24'h0, frz_r[i] ? hold_r[i][7:0] : cnt_r[i][7:0]};
      end
      if (hit(address, i, tdc_pkg::OFF_CC_HI)) begin
        rd_nxt = {24'h0, frz_r[i] ? hold_r[i][15:8] : cnt_r[i][15:8]};
      end
    end
    if (address == tdc_pkg::OFF_CFG) rd_nxt = {28'h0, cfg_r};
    if (address == tdc_pkg::OFF_STAT) rd_nxt = {29'h0, ip_r};
  end

  // Bus handshake: one wait cycle, then the answer stands at the taking edge.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (ce) begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) readdata <= rd_nxt;
    end
  end

  // Software configuration: mode, time constant halves, master interrupt enable and link controls.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_r <= tdc_pkg::CFG_RST;
      for (int i = 0; i < 3; i++) begin
        mode_r[i] <= tdc_pkg::MODE_RST;
        tc_r[i]   <= tdc_pkg::TC_RST;
      end
    end else if (ce && wr_go) begin
      for (int i = 0; i < 3; i++) begin
        if (hit(address, i, tdc_pkg::OFF_MODE)) begin
          if (byteenable[0]) mode_r[i][7:0] <= writedata[7:0];
          if (byteenable[1]) mode_r[i][9:8] <= writedata[9:8];
        end
        if (byteenable[0] && hit(address, i, tdc_pkg::OFF_TC_LO)) begin
          tc_r[i][7:0] <= writedata[7:0];
        end
        if (byteenable[0] && hit(address, i, tdc_pkg::OFF_TC_HI)) begin
          tc_r[i][15:8] <= writedata[7:0];
        end
      end
      if (byteenable[0] && address == tdc_pkg::OFF_CFG) cfg_r <= writedata[3:0];
    end
  end

  // Two-stage synchronisers; the third count stage only serves the edge detector.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_s1_r <= 3'h0;
      cnt_s2_r <= 3'h0;
      cnt_s3_r <= 3'h0;
      trg_s1_r <= 3'h0;
      trg_s2_r <= 3'h0;
      gat_s1_r <= 3'h0;
      gat_s2_r <= 3'h0;
    end else if (ce) begin
      cnt_s1_r <= raw_cnt;
      cnt_s2_r <= cnt_s1_r;
      cnt_s3_r <= cnt_s2_r;
      trg_s1_r <= raw_trg;
      trg_s2_r <= trg_s1_r;
      gat_s1_r <= raw_gat;
      gat_s2_r <= gat_s1_r;
    end
  end

  // Down-counters, progress flag and output waveform.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_r       <= 1'b0;
      cip_r       <= 3'h0;
      out_r       <= 3'h0;
      trig_prev_r <= 3'h0;
      out_prev_r  <= 3'h0;
      for (int i = 0; i < 3; i++) cnt_r[i] <= tdc_pkg::TC_RST;
    end else if (ce) begin
      div_r       <= !div_r;
      trig_prev_r <= trig_src;
      out_prev_r  <= out_r;
      for (int i = 0; i < 3; i++) begin
        if (trig_acc[i]) begin
          cnt_r[i] <= tc_r[i];
          cip_r[i] <= 1'b1;
          out_r[i] <= om(mode_r[i]) == tdc_pkg::TDC_ONESHOT;
        end else if (term[i]) begin
          if (mode_r[i][tdc_pkg::MODE_OM + 1] && !out_r[i]) begin
            out_r[i] <= 1'b1;
            cnt_r[i] <= tc_r[i];
          end else begin
            out_r[i] <= om(mode_r[i]) == tdc_pkg::TDC_PULSE;
            if (mode_r[i][tdc_pkg::MODE_CONT]) begin
              cnt_r[i] <= tc_r[i];
            end else begin
              cnt_r[i] <= cnt_r[i] - tdc_pkg::CNT_ONE;
              cip_r[i] <= 1'b0;
            end
          end
        end else if (step[i]) begin
          // A zero load wraps through all 65,536 states before the terminal step.
          cnt_r[i] <= cnt_r[i] - tdc_pkg::CNT_ONE;
          if (om(mode_r[i]) == tdc_pkg::TDC_PULSE) out_r[i] <= 1'b0;
        end else if (tick[i] && om(mode_r[i]) == tdc_pkg::TDC_PULSE) begin
          out_r[i] <= 1'b0;
        end
        if (!en[i]) out_r[i] <= 1'b0;
      end
    end
  end

  // Pending, hidden overrun, error and under-service flags.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ip_r  <= 3'h0;
      err_r <= 3'h0;
      ovr_r <= 3'h0;
      ius_r <= 3'h0;
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (term[i] && en[i]) begin
          // A new event beats a clear in the same cycle.
          ip_r[i] <= 1'b1;
          if (clr_ip[i]) begin
            err_r[i] <= ovr_r[i];
            ovr_r[i] <= 1'b0;
          end else if (ip_r[i]) begin
            ovr_r[i] <= 1'b1;
          end
        end else if (clr_ip[i]) begin
          ip_r[i]  <= ovr_r[i];
          err_r[i] <= ovr_r[i];
          ovr_r[i] <= 1'b0;
        end
        if (sel_cmd[i] && writedata[tdc_pkg::CMD_SET_US]) ius_r[i] <= 1'b1;
        if (sel_cmd[i] && writedata[tdc_pkg::CMD_CLR_US]) ius_r[i] <= 1'b0;
      end
    end
  end

  // Readback freeze: a disabled counter never holds a frozen value.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frz_r <= 3'h0;
      for (int i = 0; i < 3; i++) hold_r[i] <= tdc_pkg::TC_RST;
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (!en[i]) begin
          frz_r[i] <= 1'b0;
        end else if (sel_cmd[i] && writedata[tdc_pkg::CMD_FREEZE]) begin
          frz_r[i]  <= 1'b1;
          hold_r[i] <= cnt_r[i];
        end else if (rd_go && hit(address, i, tdc_pkg::OFF_CC_LO)) begin
          frz_r[i] <= 1'b0;
        end
      end
    end
  end

  // Pins and interrupt request are registered, one cycle behind internal state.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_b_out <= 8'h00;
      port_b_oe  <= 8'h00;
      port_c_out <= 4'h0;
      port_c_oe  <= 4'h0;
      irq        <= 1'b0;
    end else if (ce) begin
      port_b_out <= {3'h0, out_r[0], 3'h0, out_r[1]};
      port_b_oe  <= {3'h0, en[0], 3'h0, en[1]};
      port_c_out <= {3'h0, out_r[2]};
      port_c_oe  <= {3'h0, en[2]};
      irq <= cfg_r[tdc_pkg::CFG_MIE] && chain_enable_in
        && |(ip_r & en & ~ius_r & {mode_r[2][tdc_pkg::MODE_IE],
        mode_r[1][tdc_pkg::MODE_IE], mode_r[0][tdc_pkg::MODE_IE]});
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_chk
    trig_load_a: assert property (@(posedge clk) disable iff (reset)
      ce && trig_acc[g] |=> cip_r[g] && cnt_r[g] == $past(tc_r[g]))
      else $error("trigger did not load time constant");
    dis_out_a: assert property (@(posedge clk) disable iff (reset)
      ce && !en[g] |=> !out_r[g] && !frz_r[g])
      else $error("disabled counter output or freeze not clear");
    term_ip_a: assert property (@(posedge clk) disable iff (reset)
      ce && term[g] && en[g] |=> ip_r[g])
      else $error("terminal count did not set pending");
    ovr_err_a: assert property (@(posedge clk) disable iff (reset)
      ce && clr_ip[g] && ovr_r[g] && !term[g] |=> ip_r[g] && err_r[g] && !ovr_r[g])
      else $error("overrun not reported on clear");
    single_stop_a: assert property (@(posedge clk) disable iff (reset)
      ce && term[g] && !mode_r[g][tdc_pkg::MODE_CONT] && !mode_r[g][tdc_pkg::MODE_OM + 1]
      |=> !cip_r[g] && cnt_r[g] == 16'h0000)
      else $error("single cycle did not stop at zero");
    pulse_one_a: assert property (@(posedge clk) disable iff (reset)
      ce && out_r[g] && tick[g] && !term[g] && om(mode_r[g]) == tdc_pkg::TDC_PULSE
      |=> !out_r[g])
      else $error("pulse held past one counting cycle");
    no_retrig_a: assert property (@(posedge clk) disable iff (reset)
      ce && cip_r[g] && !mode_r[g][tdc_pkg::MODE_RETRG] |-> !trig_acc[g])
      else $error("trigger accepted during countdown");
  end

  chain_irq_a: assert property (@(posedge clk) disable iff (reset)
    ce && (!chain_enable_in || !cfg_r[tdc_pkg::CFG_MIE]) |=> !irq)
    else $error("interrupt raised while chain or master disabled");
endmodule
`default_nettype wire

// ===== tdc_timer_tb.sv
// Self-checking testbench for the triple counter/timer block.
`default_nettype none
module tdc_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, ce, read, write, waitrequest, irq, hs_trigger, chain_enable_in;
  logic [7:0]  address, port_b_in, port_b_out, port_b_oe;
  logic [3:0]  byteenable, port_c_in, port_c_out, port_c_oe;
  logic [31:0] writedata, readdata, q, f;
  int          errors, n_compared;

  tdc_timer dut (.clk(clk), .reset(reset), .ce(ce), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .port_b_in(port_b_in), .port_c_in(port_c_in),
    .hs_trigger(hs_trigger), .chain_enable_in(chain_enable_in), .port_b_out(port_b_out),
    .port_b_oe(port_b_oe), .port_c_out(port_c_out), .port_c_oe(port_c_oe), .irq(irq));
  tdc_pin_model src (.clk(clk), .port_b_in(port_b_in), .port_c_in(port_c_in),
    .hs_trigger(hs_trigger));

  function automatic logic [31:0] bt(input int i);
    return 32'h1 << i;
  endfunction
  function automatic logic [7:0] ra(input int n, input logic [7:0] off);
    return 8'(n) * tdc_pkg::CTR_STRIDE + off;
  endfunction
  task automatic print_verdict;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // The request is held until waitrequest is sampled low; the idle edge after it avoids
  // raising a strobe again in the time step that dropped it.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      errors++;
      print_verdict;
    end
    @(posedge clk);
  endtask
  task automatic wr(input int n, input logic [7:0] off, input logic [31:0] d);
    bus(1'b1, ra(n, off), d);
  endtask
  task automatic rd(input int n, input logic [7:0] off);
    bus(1'b0, ra(n, off), 32'h0);
  endtask
  task automatic trig(input int n);
    wr(n, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_TRIG));
  endtask

  task automatic t_reset;
    check("pins", {port_b_out, port_b_oe, port_c_out, port_c_oe, irq}, 32'h0);
    for (int n = 0; n < 3; n++) begin
      rd(n, tdc_pkg::OFF_MODE);
      check("mode", q, 32'h0);
      rd(n, tdc_pkg::OFF_CMD);
      check("status", q, 32'h0);
    end
    wr(3, 8'h1c, 32'h5a);
    rd(3, 8'h1c);
    check("unmapped", q, 32'h0);
    wr(1, tdc_pkg::OFF_TC_HI, 32'hab);
    wr(1, tdc_pkg::OFF_TC_LO, 32'hcd);
    rd(1, tdc_pkg::OFF_TC_LO);
    check("tc lo", q, 32'hcd);
    rd(1, tdc_pkg::OFF_TC_HI);
    check("tc hi", q, 32'hab);
  endtask
  task automatic t_pulse;
    int n;
    n = 0;
    wr(0, tdc_pkg::OFF_TC_LO, 32'h08);
    wr(0, tdc_pkg::OFF_TC_HI, 32'h00);
    wr(0, tdc_pkg::OFF_MODE, bt(tdc_pkg::MODE_EN) | bt(tdc_pkg::MODE_SGATE));
    trig(0);
    rd(0, tdc_pkg::OFF_CMD);
    check("cip set", q, 32'h1);
    while (port_b_out[4] !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (port_b_out[4] === 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    check("pulse width", 32'(n), 32'd2);
    rd(0, tdc_pkg::OFF_CMD);
    check("tc status", q, 32'h4);
    rd(0, tdc_pkg::OFF_CC_LO);
    check("stopped count", q, 32'h0);
    wr(0, tdc_pkg::OFF_MODE, 32'h0);
    rd(0, tdc_pkg::OFF_CMD);
    check("pending kept", q, 32'h4);
    check("oe off", 32'(port_b_oe[4]), 32'h0);
  endtask
  task automatic t_irq;
    chain_enable_in <= 1'b1;
    wr(0, tdc_pkg::OFF_MODE, bt(tdc_pkg::MODE_EN) | bt(tdc_pkg::MODE_IE));
    wr(0, tdc_pkg::OFF_CFG, bt(tdc_pkg::CFG_MIE));
    cyc(2);
    check("irq on", 32'(irq), 32'h1);
    chain_enable_in <= 1'b0;
    cyc(3);
    check("irq chain", 32'(irq), 32'h0);
    chain_enable_in <= 1'b1;
    wr(0, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_SET_US));
    cyc(2);
    check("irq service", 32'(irq), 32'h0);
    wr(0, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_CLR_US));
    rd(0, tdc_pkg::OFF_STAT);
    check("global pending", q, 32'h1);
    check("irq back", 32'(irq), 32'h1);
    wr(0, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_CLR_IP));
    cyc(2);
    check("irq clear", 32'(irq), 32'h0);
  endtask
  task automatic t_overrun;
    wr(0, tdc_pkg::OFF_MODE, bt(tdc_pkg::MODE_EN) | bt(tdc_pkg::MODE_SGATE));
    trig(0);
    cyc(30);
    trig(0);
    cyc(30);
    rd(0, tdc_pkg::OFF_CMD);
    check("hidden err", q, 32'h4);
    wr(0, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_CLR_IP));
    rd(0, tdc_pkg::OFF_CMD);
    check("err shown", q, 32'hc);
    wr(0, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_CLR_IP));
    rd(0, tdc_pkg::OFF_CMD);
    check("err clear", q, 32'h0);
  endtask
  task automatic t_pins;
    wr(1, tdc_pkg::OFF_TC_LO, 32'h03);
    wr(1, tdc_pkg::OFF_TC_HI, 32'h00);
    wr(1, tdc_pkg::OFF_MODE, bt(tdc_pkg::MODE_EN) | bt(tdc_pkg::MODE_SGATE) |
      bt(tdc_pkg::MODE_ECNT) | bt(tdc_pkg::MODE_ETRIG) | bt(tdc_pkg::MODE_EGATE) |
      bt(tdc_pkg::MODE_OM));
    src.pulse(2);
    rd(1, tdc_pkg::OFF_CC_LO);
    check("pin load", q, 32'h3);
    check("oneshot up", 32'(port_b_out[0]), 32'h1);
    src.level(3, 1'b0);
    src.pulse(1);
    rd(1, tdc_pkg::OFF_CC_LO);
    check("gated", q, 32'h3);
    src.level(3, 1'b1);
    src.pulse(1);
    src.pulse(1);
    rd(1, tdc_pkg::OFF_CC_LO);
    check("counted", q, 32'h1);
    src.pulse(1);
    cyc(4);
    check("oneshot down", 32'(port_b_out[0]), 32'h0);
    rd(1, tdc_pkg::OFF_CMD);
    check("pin tc", q, 32'h4);
  endtask
  task automatic t_freeze;
    trig(2);
    rd(2, tdc_pkg::OFF_CMD);
    check("trig off", q, 32'h0);
    wr(2, tdc_pkg::OFF_TC_LO, 32'h00);
    wr(2, tdc_pkg::OFF_TC_HI, 32'h00);
    wr(2, tdc_pkg::OFF_MODE, bt(tdc_pkg::MODE_EN) | bt(tdc_pkg::MODE_SGATE));
    trig(2);
    rd(2, tdc_pkg::OFF_CC_HI);
    check("full span", q, 32'hff);
    wr(2, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_FREEZE));
    rd(2, tdc_pkg::OFF_CMD);
    check("frozen", q, 32'h3);
    cyc(30);
    rd(2, tdc_pkg::OFF_CC_LO);
    f = q;
    rd(2, tdc_pkg::OFF_CMD);
    check("thawed", q, 32'h1);
    rd(2, tdc_pkg::OFF_CC_LO);
    check("tracking", 32'((f[7:0] - q[7:0]) >= 8'h0f), 32'h1);
    wr(2, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_FREEZE));
    wr(2, tdc_pkg::OFF_MODE, 32'h0);
    rd(2, tdc_pkg::OFF_CMD);
    check("freeze cleared", 32'(q[1]), 32'h0);
    wr(2, tdc_pkg::OFF_CMD, bt(tdc_pkg::CMD_FREEZE));
    rd(2, tdc_pkg::OFF_CMD);
    check("freeze held", 32'(q[1]), 32'h0);
    check("out off", {28'h0, port_c_out}, 32'h0);
  endtask
  // Continuous square wave on counter 1, clock-enable freeze, handshake trigger on counter 3.
  task automatic t_square;
    int n;
    n = 0;
    wr(0, tdc_pkg::OFF_TC_LO, 32'h02);
    wr(0, tdc_pkg::OFF_TC_HI, 32'h00);
    wr(0, tdc_pkg::OFF_MODE, bt(tdc_pkg::MODE_EN) | bt(tdc_pkg::MODE_SGATE) |
      bt(tdc_pkg::MODE_CONT) | bt(tdc_pkg::MODE_OM + 1));
    trig(0);
    while (port_b_out[4] !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (port_b_out[4] === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("square high", 32'(n), 32'd4);
    ce <= 1'b0;
    @(posedge clk);
    f = {24'h0, port_b_out};
    cyc(10);
    check("ce freeze", {24'h0, port_b_out}, f);
    ce <= 1'b1;
    @(posedge clk);
    rd(0, tdc_pkg::OFF_CMD);
    check("square pending", 32'(q[2]), 32'h1);
    wr(0, tdc_pkg::OFF_MODE, 32'h0);
    wr(2, tdc_pkg::OFF_TC_LO, 32'h10);
    wr(2, tdc_pkg::OFF_MODE, bt(tdc_pkg::MODE_EN) | bt(tdc_pkg::MODE_SGATE));
    src.pulse(12);
    rd(2, tdc_pkg::OFF_CMD);
    check("hs trigger", 32'(q[0]), 32'h1);
    wr(2, tdc_pkg::OFF_MODE, 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    print_verdict;
  end
  initial begin
    errors = 0;
    n_compared = 0;
    reset = 1'b1;
    ce = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    byteenable = 4'h3;
    writedata = 32'h0;
    chain_enable_in = 1'b0;
    cyc(2);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_pulse;
    t_irq;
    t_overrun;
    t_pins;
    t_freeze;
    t_square;
    print_verdict;
  end
endmodule
`default_nettype wire
